// file: inc/pma_pkg.sv
package pma_pkg;

  // ===========================================================
  // register offsets
  localparam logic [7:0] PMA_OFS_CONFIG  = 8'h00;
  localparam logic [7:0] PMA_OFS_SHUNT   = 8'h01;
  localparam logic [7:0] PMA_OFS_BUS     = 8'h02;
  localparam logic [7:0] PMA_OFS_POWER   = 8'h03;
  localparam logic [7:0] PMA_OFS_CURRENT = 8'h04;
  localparam logic [7:0] PMA_OFS_CAL     = 8'h05;
  localparam logic [7:0] PMA_OFS_MASK    = 8'h06;
  localparam logic [7:0] PMA_OFS_LIMIT   = 8'h07;

  // ===========================================================
  // reset values
  localparam logic [15:0] PMA_CONFIG_RST = 16'h0127;
  localparam logic [15:0] PMA_MASK_RST   = 16'h0000;
  localparam logic [15:0] PMA_CAL_RST    = 16'h0000;
  localparam logic [15:0] PMA_LIMIT_RST  = 16'h0000;

  // ===========================================================
  // field layouts (msb first)
  typedef struct packed {
    logic [3:0] rsv;
    logic [2:0] avg;
    logic [2:0] bus_ct;
    logic [2:0] shunt_ct;
    logic [2:0] mode;     // bit0 shunt, bit1 bus, bit2 continuous
  } pma_config_t;

  typedef struct packed {
    logic       shunt_over_limit_en;   // d15
    logic       shunt_under_limit_en;  // d14
    logic       bus_over_limit_en;     // d13
    logic       bus_under_limit_en;    // d12
    logic       power_over_limit_en;   // d11
    logic       conv_ready_alert_en;   // d10
    logic [4:0] rsv_hi;
    logic       limit_violation_flag;  // d4
    logic       conv_ready_flag;       // d3
    logic       rsv_lo;
    logic       alert_active_level;    // d1
    logic       alert_latch_en;        // d0
  } pma_mask_t;

  typedef struct packed {
    logic [15:0] shunt;
    logic [15:0] bus;
    logic [15:0] current;
    logic [15:0] power;
  } pma_meas_t;

  typedef enum logic [2:0] {
    PMA_ST_OFF,
    PMA_ST_SHUNT,
    PMA_ST_BUS,
    PMA_ST_CALC,
    PMA_ST_ACC
  } pma_state_t;

  // ===========================================================
  // timing and scaling
  localparam int PMA_CLK_MHZ = 10;
  localparam int PMA_CT_US [0:7] = '{140, 204, 332, 588,
                                     1100, 2116, 4156, 8244};
  localparam int PMA_CT_CYC [0:7] = '{
    PMA_CT_US[0] * PMA_CLK_MHZ, PMA_CT_US[1] * PMA_CLK_MHZ,
    PMA_CT_US[2] * PMA_CLK_MHZ, PMA_CT_US[3] * PMA_CLK_MHZ,
    PMA_CT_US[4] * PMA_CLK_MHZ, PMA_CT_US[5] * PMA_CLK_MHZ,
    PMA_CT_US[6] * PMA_CLK_MHZ, PMA_CT_US[7] * PMA_CLK_MHZ};
  // averages 1,4,16,64,128,256,512,1024 as shifts
  localparam logic [3:0] PMA_AVG_SHIFT [0:7] = '{4'h0, 4'h2, 4'h4, 4'h6,
                                                 4'h7, 4'h8, 4'h9, 4'ha};
  localparam int PMA_CUR_SHIFT = 11;     // divide by 2048
  localparam int PMA_PWR_DIV   = 20000;

endpackage

// file: src/pma_calc.sv
`timescale 1ns/1ps
module pma_calc
  import pma_pkg::*;
(
  input  wire logic        mclk_in,      // system clock
  input  wire logic        rst_in,       // sync reset, high
  input  wire logic [15:0] shunt_in,     // shunt sample code
  input  wire logic [15:0] bus_in,       // bus sample code
  input  wire logic [15:0] cal_in,       // calibration value
  output logic      [15:0] current_out,  // current code
  output logic      [15:0] power_out     // power code
);

  typedef struct packed {
    logic [15:0] current;
    logic [15:0] power;
  } pma_calc_s_t;

  pma_calc_s_t        s_q;
  pma_calc_s_t        s_d;
  logic signed [32:0] prod;
  logic signed [32:0] prod_adj;
  logic signed [21:0] cur_full;
  logic        [16:0] cur_mag;
  logic        [32:0] pwr_prod;
  logic        [32:0] pwr_full;

  // ===========================================================
  // current and power
  always_comb begin
    s_d = s_q;
    prod = $signed(shunt_in) * $signed({1'b0, cal_in});
    // truncate toward zero like an integer divide
    prod_adj = prod[32] ? prod + 33'sd2047 : prod;
    cur_full = 22'(prod_adj >>> PMA_CUR_SHIFT);
    s_d.current = cur_full[15:0];
    cur_mag = cur_full[15] ? 17'(-$signed({cur_full[15], cur_full[15:0]}))
                           : {1'b0, cur_full[15:0]};
    // power scaling, gives 25x current step
    pwr_prod = 33'({16'h0000, cur_mag} * {17'h00000, bus_in});
    pwr_full = pwr_prod / 33'(PMA_PWR_DIV);
    s_d.power = pwr_full[15:0];
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign current_out = s_q.current;
  assign power_out   = s_q.power;

endmodule // pma_calc

// file: src/pma_alert.sv
`timescale 1ns/1ps
module pma_alert
  import pma_pkg::*;
(
  input  wire pma_mask_t   sel_in,     // alert function selection
  input  wire logic [15:0] limit_in,   // alert threshold
  input  wire logic [15:0] shunt_in,   // per-sample shunt code
  input  wire logic [15:0] bus_in,     // per-sample bus code
  input  wire logic [15:0] power_in,   // per-sample power code
  input  wire logic        shunt_new_in, // shunt converted this set
  input  wire logic        bus_new_in, // bus converted this set
  output logic             hit_out,    // a comparison applies
  output logic             viol_out    // comparison violates limit
);

  // ===========================================================
  // priority comparator
  always_comb begin
    hit_out  = 1'b0;
    viol_out = 1'b0;
    if (sel_in.shunt_over_limit_en) begin
      hit_out  = shunt_new_in;
      viol_out = $signed(shunt_in) > $signed(limit_in);
    end else if (sel_in.shunt_under_limit_en) begin
      hit_out  = shunt_new_in;
      viol_out = $signed(shunt_in) < $signed(limit_in);
    end else if (sel_in.bus_over_limit_en) begin
      hit_out  = bus_new_in;
      viol_out = bus_in > limit_in;
    end else if (sel_in.bus_under_limit_en) begin
      hit_out  = bus_new_in;
      viol_out = bus_in < limit_in;
    end else if (sel_in.power_over_limit_en) begin
      hit_out  = bus_new_in;
      viol_out = power_in > limit_in;
    end
  end

endmodule // pma_alert

// file: src/pma_monitor.sv
`timescale 1ns/1ps
module pma_monitor
  import pma_pkg::*;
#(
  // cycles per conversion time code; shorten for simulation
  parameter int CONV_CYC [0:7] = PMA_CT_CYC
) (
  input  wire logic        mclk_in,        // system clock, 10 MHz
  input  wire logic        rst_in,         // sync reset, high
  input  wire logic [7:0]  reg_addr_in,    // register pointer
  input  wire logic        reg_wr_in,      // write strobe
  input  wire logic        reg_rd_in,      // read strobe
  input  wire logic [15:0] reg_wdata_in,   // write data
  output logic      [15:0] reg_rdata_out,  // read data, next cycle
  output logic             adc_busy_out,   // converter running
  output logic             adc_sel_out,    // 0 shunt, 1 bus
  output logic             adc_sample_out, // conversion end pulse
  input  wire logic [15:0] adc_data_in,    // converter result
  output logic             alert_out,      // open-drain level, low
  output logic             alert_oe_out    // high pulls pin low
);

  typedef struct packed {
    pma_state_t         st;
    logic [16:0]        timer;
    logic [9:0]         avg_cnt;
    pma_config_t        config_r;
    pma_mask_t          mask;
    logic [15:0]        cal;
    logic [15:0]        limit;
    logic [15:0]        shunt_smp;
    logic [15:0]        bus_smp;
    logic               shunt_new;
    logic               bus_new;
    logic signed [26:0] acc_shunt;
    logic signed [26:0] acc_bus;
    logic signed [26:0] acc_cur;
    logic signed [26:0] acc_pwr;
    pma_meas_t          res;
    logic [15:0]        rdata;
    logic               sample;
    logic               alert_oe;
  } pma_mon_s_t;

  pma_mon_s_t  s_q;
  pma_mon_s_t  s_d;
  logic [15:0] calc_cur;
  logic [15:0] calc_pwr;
  logic        cmp_hit;
  logic        cmp_viol;
  logic        cfg_wr;
  logic        mask_rd;
  logic        conv_end;
  logic [16:0] conv_last;
  logic [9:0]  avg_last;
  logic [3:0]  shamt;
  logic        pd_write;
  logic        set_aff;
  logic        clr_aff;
  logic        alert_asserted;
  pma_config_t wcfg;

  // ===========================================================
  // helpers
  // first conversion of a set for a given mode
  function automatic pma_state_t first_state(input logic [2:0] mode);
    if (mode[0]) begin
      return PMA_ST_SHUNT;
    end else if (mode[1]) begin
      return PMA_ST_BUS;
    end else begin
      return PMA_ST_OFF;
    end
  endfunction

  function automatic logic [26:0] sext16(input logic [15:0] v);
    return {{11{v[15]}}, v};
  endfunction

  // ===========================================================
  // arithmetic and comparison
  pma_calc u_calc (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .shunt_in    (s_q.shunt_smp),
    .bus_in      (s_q.bus_smp),
    .cal_in      (s_q.cal),
    .current_out (calc_cur),
    .power_out   (calc_pwr)
  );

  pma_alert u_alert (
    .sel_in       (s_q.mask),
    .limit_in     (s_q.limit),
    .shunt_in     (s_q.shunt_smp),
    .bus_in       (s_q.bus_smp),
    .power_in     (calc_pwr),
    .shunt_new_in (s_q.shunt_new),
    .bus_new_in   (s_q.bus_new),
    .hit_out      (cmp_hit),
    .viol_out     (cmp_viol)
  );

  // ===========================================================
  // next state
  always_comb begin
    s_d      = s_q;
    s_d.sample = 1'b0;
    cfg_wr   = reg_wr_in && (reg_addr_in == PMA_OFS_CONFIG);
    mask_rd  = reg_rd_in && (reg_addr_in == PMA_OFS_MASK);
    wcfg     = pma_config_t'(reg_wdata_in);
    pd_write = cfg_wr && (wcfg.mode[1:0] == 2'b00);
    set_aff  = 1'b0;
    clr_aff  = 1'b0;
    shamt    = PMA_AVG_SHIFT[s_q.config_r.avg];
    avg_last = 10'((11'h001 << shamt) - 11'h001);

    if (s_q.st == PMA_ST_BUS) begin
      conv_last = 17'(CONV_CYC[s_q.config_r.bus_ct] - 1);
    end else begin
      conv_last = 17'(CONV_CYC[s_q.config_r.shunt_ct] - 1);
    end
    conv_end = (s_q.timer == conv_last);

    // register reads
    if (reg_rd_in) begin
      case (reg_addr_in)
        PMA_OFS_CONFIG:  s_d.rdata = s_q.config_r;
        PMA_OFS_SHUNT:   s_d.rdata = s_q.res.shunt;
        PMA_OFS_BUS:     s_d.rdata = s_q.res.bus;
        PMA_OFS_POWER:   s_d.rdata = s_q.res.power;
        PMA_OFS_CURRENT: s_d.rdata = s_q.res.current;
        PMA_OFS_CAL:     s_d.rdata = s_q.cal;
        PMA_OFS_MASK:    s_d.rdata = s_q.mask;
        PMA_OFS_LIMIT:   s_d.rdata = s_q.limit;
        default:         s_d.rdata = 16'h0000;
      endcase
    end

    // register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        PMA_OFS_CONFIG: begin
          s_d.config_r     = wcfg;
          s_d.config_r.rsv = 4'h0;
        end
        // new calibration applies to later samples
        PMA_OFS_CAL: s_d.cal = reg_wdata_in;
        PMA_OFS_MASK: begin
          s_d.mask.shunt_over_limit_en  = reg_wdata_in[15];
          s_d.mask.shunt_under_limit_en = reg_wdata_in[14];
          s_d.mask.bus_over_limit_en    = reg_wdata_in[13];
          s_d.mask.bus_under_limit_en   = reg_wdata_in[12];
          s_d.mask.power_over_limit_en  = reg_wdata_in[11];
          s_d.mask.conv_ready_alert_en  = reg_wdata_in[10];
          s_d.mask.alert_active_level   = reg_wdata_in[1];
          s_d.mask.alert_latch_en       = reg_wdata_in[0];
        end
        PMA_OFS_LIMIT: s_d.limit = reg_wdata_in;
        default: ;
      endcase
    end

    // conversion sequencer
    case (s_q.st)
      PMA_ST_OFF: begin
        s_d.timer = 17'h00000;
        // continuous modes leave idle by themselves, e.g. after reset
        if (s_q.config_r.mode[2]) begin
          s_d.st = first_state(s_q.config_r.mode);
        end
      end
      PMA_ST_SHUNT: begin
        s_d.timer = 17'(s_q.timer + 17'h00001);
        if (conv_end) begin
          s_d.timer     = 17'h00000;
          s_d.sample    = 1'b1;
          s_d.shunt_smp = adc_data_in;
          s_d.shunt_new = 1'b1;
          s_d.st = s_q.config_r.mode[1] ? PMA_ST_BUS : PMA_ST_CALC;
        end
      end
      PMA_ST_BUS: begin
        s_d.timer = 17'(s_q.timer + 17'h00001);
        if (conv_end) begin
          s_d.timer   = 17'h00000;
          s_d.sample  = 1'b1;
          s_d.bus_smp = adc_data_in;
          s_d.bus_new = 1'b1;
          s_d.st      = PMA_ST_CALC;
        end
      end
      PMA_ST_CALC: begin
        // one cycle for the registered multiplier
        s_d.st = PMA_ST_ACC;
      end
      PMA_ST_ACC: begin
        // compare raw sample, not the average
        if (cmp_hit) begin
          if (cmp_viol) begin
            set_aff = 1'b1;
          end else if (!s_q.mask.alert_latch_en) begin
            clr_aff = 1'b1;
          end
        end
        s_d.acc_shunt = 27'(s_q.acc_shunt + sext16(s_q.shunt_smp));
        s_d.acc_bus   = 27'(s_q.acc_bus + {11'h000, s_q.bus_smp});
        s_d.acc_cur   = 27'(s_q.acc_cur + sext16(calc_cur));
        s_d.acc_pwr   = 27'(s_q.acc_pwr + {11'h000, calc_pwr});
        s_d.shunt_new = 1'b0;
        s_d.bus_new   = 1'b0;
        s_d.avg_cnt   = 10'(s_q.avg_cnt + 10'h001);
        s_d.st        = first_state(s_q.config_r.mode);
        if (s_q.avg_cnt == avg_last) begin
          // load averages only when count is complete
          s_d.res.shunt   = 16'(s_d.acc_shunt >>> shamt);
          s_d.res.bus     = 16'(s_d.acc_bus >>> shamt);
          s_d.res.current = 16'(s_d.acc_cur >>> shamt);
          s_d.res.power   = 16'(s_d.acc_pwr >>> shamt);
          s_d.acc_shunt   = '0;
          s_d.acc_bus     = '0;
          s_d.acc_cur     = '0;
          s_d.acc_pwr     = '0;
          s_d.avg_cnt     = 10'h000;
          s_d.mask.conv_ready_flag = 1'b1;
          if (!s_q.config_r.mode[2]) begin
            s_d.st = PMA_ST_OFF;
          end
        end
      end
      default: begin
        s_d.st = PMA_ST_OFF;
      end
    endcase

    // a config write restarts the set, also for single shot
    if (cfg_wr) begin
      s_d.st        = first_state(wcfg.mode);
      s_d.timer     = 17'h00000;
      s_d.avg_cnt   = 10'h000;
      s_d.shunt_new = 1'b0;
      s_d.bus_new   = 1'b0;
      s_d.acc_shunt = '0;
      s_d.acc_bus   = '0;
      s_d.acc_cur   = '0;
      s_d.acc_pwr   = '0;
    end

    // ready flag clear; a set in the same cycle wins
    if ((cfg_wr && !pd_write) || mask_rd) begin
      if (!(s_q.st == PMA_ST_ACC && s_q.avg_cnt == avg_last)) begin
        s_d.mask.conv_ready_flag = 1'b0;
      end
    end

    // latched flag cleared by config write or mask read
    if (s_q.mask.alert_latch_en && (cfg_wr || mask_rd)) begin
      clr_aff = 1'b1;
    end
    // violation sets flag, set beats clear
    if (set_aff) begin
      s_d.mask.limit_violation_flag = 1'b1;
    end else if (clr_aff) begin
      s_d.mask.limit_violation_flag = 1'b0;
    end
    s_d.mask.rsv_hi = 5'h00;
    s_d.mask.rsv_lo = 1'b0;

    // either cause drives the shared pin
    // ready ignored unless its enable is set
    alert_asserted = s_d.mask.limit_violation_flag ||
                     (s_d.mask.conv_ready_alert_en &&
                      s_d.mask.conv_ready_flag);
    // polarity: 0 asserts low, 1 asserts high
    s_d.alert_oe = s_d.mask.alert_active_level ? !alert_asserted
                                               : alert_asserted;
  end

  // ===========================================================
  // state register
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_q          <= '0;
      s_q.st       <= PMA_ST_OFF;
      s_q.config_r <= pma_config_t'(PMA_CONFIG_RST);
      s_q.mask     <= pma_mask_t'(PMA_MASK_RST);
      s_q.cal      <= PMA_CAL_RST;
      s_q.limit    <= PMA_LIMIT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ===========================================================
  // outputs
  assign reg_rdata_out  = s_q.rdata;
  assign adc_busy_out   = (s_q.st == PMA_ST_SHUNT) ||
                          (s_q.st == PMA_ST_BUS);
  assign adc_sel_out    = (s_q.st == PMA_ST_BUS);
  assign adc_sample_out = s_q.sample;
  assign alert_out      = 1'b0;
  assign alert_oe_out   = s_q.alert_oe;

endmodule // pma_monitor

// file: verif/pma_adc_model.sv
`timescale 1ns/1ps
module pma_adc_model (
  input  wire logic        mclk_in,  // system clock
  input  wire logic        busy_in,  // conversion running
  input  wire logic        sel_in,   // 0 shunt, 1 bus
  input  wire logic [15:0] shunt_in, // shunt code to report
  input  wire logic [15:0] bus_in,   // bus code to report
  output logic      [15:0] data_out  // converter result
);
  logic [15:0] last_q = 16'h0000;

  // ===========================================================
  // converter result
  // idle output is the inverse of the last code, so a capture
  // outside a conversion cannot match by luck
  always @(posedge mclk_in) begin
    if (busy_in) begin
      last_q <= sel_in ? bus_in : shunt_in;
    end
  end
  assign data_out = busy_in ? (sel_in ? bus_in : shunt_in) : ~last_q;
endmodule // pma_adc_model

// file: verif/pma_monitor_properties.sv
`timescale 1ns/1ps
module pma_monitor_properties
  import pma_pkg::*;
(
  input wire logic        mclk_in,        // system clock
  input wire logic        rst_in,         // sync reset
  input wire logic [7:0]  reg_addr_in,    // register pointer
  input wire logic        reg_wr_in,      // write strobe
  input wire logic        reg_rd_in,      // read strobe
  input wire logic [15:0] reg_wdata_in,   // write data
  input wire logic [15:0] reg_rdata_out,  // read data
  input wire logic        adc_busy_out,   // converter running
  input wire logic        adc_sel_out,    // shunt or bus
  input wire logic        adc_sample_out, // conversion end
  input wire logic [15:0] adc_data_in,    // converter code
  input wire logic        alert_out,      // pin data
  input wire logic        alert_oe_out    // pin enable
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  // ===========================================================
  // pin and converter
  alert_pin_low_a: assert property (alert_out == 1'b0)
    else $error("alert pin data not low");
  sample_pulse_a: assert property (
    adc_sample_out |=> !adc_sample_out)
    else $error("sample pulse longer than one cycle");
  sample_after_conv_a: assert property (
    adc_sample_out && !$past(reg_wr_in) |-> $past(adc_busy_out)
    && (!adc_busy_out || adc_sel_out != $past(adc_sel_out)))
    else $error("sample pulse without a finished conversion");
  pin_polarity_a: assert property (
    reg_rd_in && reg_addr_in == 8'h06 |=> $past(alert_oe_out) ==
    (reg_rdata_out[1] ^ (reg_rdata_out[4]
    | (reg_rdata_out[10] & reg_rdata_out[3]))))
    else $error("alert pin does not follow flags and polarity");

  // ===========================================================
  // register port
  rdata_hold_a: assert property (
    !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  unmapped_zero_a: assert property (
    reg_rd_in && reg_addr_in > 8'h07 |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  limit_readback_a: assert property (
    reg_wr_in && reg_addr_in == 8'h07 ##1 !reg_wr_in ##1 reg_rd_in
    && !reg_wr_in && reg_addr_in == 8'h07
    |=> reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("threshold read back differs");
  mask_rsv_a: assert property (
    reg_rd_in && reg_addr_in == 8'h06
    |=> reg_rdata_out[9:5] == 5'h00 && !reg_rdata_out[2])
    else $error("reserved mask bits not zero");
endmodule // pma_monitor_properties

bind pma_monitor pma_monitor_properties chk_u (
  .mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .adc_busy_out(adc_busy_out), .adc_sel_out(adc_sel_out),
  .adc_sample_out(adc_sample_out), .adc_data_in(adc_data_in),
  .alert_out(alert_out), .alert_oe_out(alert_oe_out));

// file: verif/test_power_monitor_alert_averaging.sv
`timescale 1ns/1ps
module test_power_monitor_alert_averaging;
  import pma_pkg::*;
  localparam int CONV [0:7] = '{4, 5, 6, 7, 8, 9, 10, 11};
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  reg_addr_in = 8'h00;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic [15:0] shunt_v = 16'h1f40;
  logic [15:0] bus_v = 16'h2570;
  logic [15:0] reg_rdata_out, adc_data_in, rv, cal_v, cur_e;
  logic        adc_busy_out, adc_sel_out, alert_oe_out;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  logic [15:0] run_cnt [2] = '{16'h0000, 16'h0000};
  logic [15:0] run_len [2];
  logic [15:0] tm [9] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
    16'h0800, 16'h0800, 16'hc000, 16'h8002, 16'h4002};
  logic [15:0] tl [9] = '{16'h1f00, 16'h1f00, 16'h2500, 16'h2600,
    16'h1000, 16'h1300, 16'h2000, 16'h1f00, 16'h1f00};
  logic        tv [9] = '{1, 0, 1, 1, 1, 0, 0, 1, 0};

  always #50 mclk_in = ~mclk_in;

  pma_monitor #(.CONV_CYC(CONV)) dut_u (
    .mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .adc_busy_out(adc_busy_out), .adc_sel_out(adc_sel_out),
    .adc_sample_out(), .adc_data_in(adc_data_in), .alert_out(),
    .alert_oe_out(alert_oe_out));
  pma_adc_model adc_u (
    .mclk_in(mclk_in), .busy_in(adc_busy_out), .sel_in(adc_sel_out),
    .shunt_in(shunt_v), .bus_in(bus_v), .data_out(adc_data_in));

  // ===========================================================
  // access tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge mclk_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge mclk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge mclk_in);
    reg_rd_in = 1'b0;
    d = reg_rdata_out;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    reg_rd(a, d);
    chk($sformatf("register %h", a), e, d);
  endtask
  // a mask read clears the ready flag, so polling also acknowledges it
  task automatic wait_rdy();
    rv[3] = 1'b0;
    for (int i = 0; i < 60 && rv[3] !== 1'b1; i++) begin
      reg_rd(PMA_OFS_MASK, rv);
    end
    chk("ready flag", 16'h0001, {15'h0, rv[3]});
    rv[3] = 1'b0;
  endtask
  task automatic wait_oe();
    for (int i = 0; i < 100 && alert_oe_out !== 1'b1; i++) begin
      @(negedge mclk_in);
    end
    chk("alert pin", 16'h0001, {15'h0, alert_oe_out});
  endtask

  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      wrap_up();
    end
  end

  // length of the last finished conversion of each kind
  always @(negedge mclk_in) begin
    if (adc_busy_out) begin
      run_cnt[adc_sel_out] <= run_cnt[adc_sel_out] + 16'h0001;
    end
    for (int k = 0; k < 2; k++) begin
      if (run_cnt[k] != 16'h0000 &&
          !(adc_busy_out && adc_sel_out == k[0])) begin
        run_len[k] <= run_cnt[k];
        run_cnt[k] <= 16'h0000;
      end
    end
  end

  // ===========================================================
  // tests
  initial begin
    rv = 16'h0000;
    repeat (6) @(negedge mclk_in);
    rst_in = 1'b0;
    rd_chk(PMA_OFS_MASK, 16'h0000);
    rd_chk(PMA_OFS_CONFIG, 16'h0127);
    rd_chk(PMA_OFS_CAL, 16'h0000);
    rd_chk(PMA_OFS_LIMIT, 16'h0000);
    reg_wr(8'h08, 16'hffff);
    rd_chk(8'h08, 16'h0000);
    reg_wr(PMA_OFS_LIMIT, 16'h1234);
    rd_chk(PMA_OFS_LIMIT, 16'h1234);
    wait_rdy();
    rd_chk(PMA_OFS_SHUNT, shunt_v);
    rd_chk(PMA_OFS_CURRENT, 16'h0000);
    rd_chk(PMA_OFS_POWER, 16'h0000);
    $display("test reset and uncalibrated done");
    // 1 mA step exceeds 15 A over 2^15, 2 mohm shunt
    cal_v = 16'(int'(0.00512 / (0.001 * 0.002)));
    cur_e = 16'((32'(shunt_v) * 32'(cal_v)) >> 11);
    reg_wr(PMA_OFS_CAL, cal_v);
    reg_wr(PMA_OFS_CONFIG, 16'h0127);
    wait_rdy();
    rd_chk(PMA_OFS_CURRENT, cur_e);
    rd_chk(PMA_OFS_POWER, 16'((32'(cur_e) * 32'(bus_v)) / 20000));
    rd_chk(PMA_OFS_BUS, bus_v);
    $display("test calibration done");
    shunt_v = 16'h0100;
    reg_wr(PMA_OFS_CONFIG, 16'h023f);
    rd_chk(PMA_OFS_CONFIG, 16'h023f);
    repeat (36) @(negedge mclk_in);
    rd_chk(PMA_OFS_SHUNT, 16'h1f40);
    wait_rdy();
    rd_chk(PMA_OFS_SHUNT, 16'h0100);
    rd_chk(PMA_OFS_CURRENT, 16'((32'h0100 * 32'(cal_v)) >> 11));
    chk("shunt conversion", 16'(CONV[7]), run_len[0]);
    chk("bus conversion", 16'(CONV[0]), run_len[1]);
    shunt_v = 16'h1f40;
    $display("test averaging done");
    for (int i = 0; i < 9; i++) begin
      reg_wr(PMA_OFS_LIMIT, tl[i]);
      reg_wr(PMA_OFS_MASK, tm[i]);
      reg_wr(PMA_OFS_CONFIG, 16'h0127);
      wait_rdy();
      chk("limit flag", {15'h0, tv[i]}, {15'h0, rv[4]});
      chk("pin", {15'h0, tv[i] ^ tm[i][1]}, {15'h0, alert_oe_out});
    end
    $display("test alert functions done");
    for (int i = 0; i < 2; i++) begin
      reg_wr(PMA_OFS_MASK, i ? 16'h8400 : 16'h0400);
      reg_wr(PMA_OFS_CONFIG, 16'h0127);
      wait_oe();
      reg_rd(PMA_OFS_MASK, rv);
      chk("ready flag", 16'h0001, {15'h0, rv[3]});
      chk("limit flag", {15'h0, i[0]}, {15'h0, rv[4]});
      reg_wr(PMA_OFS_CONFIG, 16'h0127);
      reg_rd(PMA_OFS_MASK, rv);
      chk("ready cleared", 16'h0000, {15'h0, rv[3]});
    end
    $display("test shared pin done");
    for (int i = 0; i < 2; i++) begin
      reg_wr(PMA_OFS_MASK, i ? 16'h8000 : 16'h8001);
      reg_wr(PMA_OFS_CONFIG, 16'h0127);
      wait_oe();
      shunt_v = 16'h0100;
      repeat (60) @(negedge mclk_in);
      chk("held pin", {15'h0, !i[0]}, {15'h0, alert_oe_out});
      reg_rd(PMA_OFS_MASK, rv);
      chk("held flag", {15'h0, !i[0]}, {15'h0, rv[4]});
      repeat (2) @(negedge mclk_in);
      chk("released pin", 16'h0000, {15'h0, alert_oe_out});
      shunt_v = 16'h1f40;
    end
    $display("test latching done");
    // single shot stops after one set; power down keeps the ready flag
    reg_wr(PMA_OFS_CONFIG, 16'h0123);
    wait_rdy();
    repeat (40) @(negedge mclk_in);
    chk("converter idle", 16'h0000, {15'h0, adc_busy_out});
    reg_rd(PMA_OFS_MASK, rv);
    chk("ready after single shot", 16'h0000, {15'h0, rv[3]});
    reg_wr(PMA_OFS_CONFIG, 16'h0123);
    repeat (25) @(negedge mclk_in);
    reg_wr(PMA_OFS_CONFIG, 16'h0120);
    reg_rd(PMA_OFS_MASK, rv);
    chk("ready kept in power down", 16'h0001, {15'h0, rv[3]});
    $display("test single shot and power down done");
    wrap_up();
  end
endmodule // test_power_monitor_alert_averaging
